// ### shared/dwpr_pkg.sv
`default_nettype none
package dwpr_pkg;
   // clock and timing
   localparam int CLK_NS      = 8;
   localparam int FLAG_MIN_NS = 125;
   localparam int DD_HALF_NS  = 1000;
   localparam int SD_HALF_NS  = 2000;
   localparam int PULSE_NS    = 250;
   localparam int WG_LEAD_NS  = 1000;
   localparam int GUARD_NS    = 100;
   localparam int FLAG_MIN_CYC = (FLAG_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int DD_HALF_CYC  = (DD_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int SD_HALF_CYC  = (SD_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WG_LEAD_CYC  = (WG_LEAD_NS + CLK_NS - 1) / CLK_NS;
   localparam int GUARD_CYC    = (GUARD_NS + CLK_NS - 1) / CLK_NS;
   // register byte offsets
   localparam logic [7:0] CMD_OFS    = 8'h00;
   localparam logic [7:0] TRACK_OFS  = 8'h04;
   localparam logic [7:0] WDATA_OFS  = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] CTRL_OFS   = 8'h10;
   // operation codes in the command register
   localparam logic [1:0] OP_ABORT    = 2'h0;
   localparam logic [1:0] OP_POSITION = 2'h1;
   localparam logic [1:0] OP_READ     = 2'h2;
   localparam logic [1:0] OP_WRITE    = 2'h3;
   localparam logic [7:0] INNER_TRACK = 8'h2b;
   localparam logic [3:0] LAST_HALF   = 4'hf;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_LEAD  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_READ  = 4'b1000
   } dwpr_state_e;
endpackage
`default_nettype wire

// ### hdl/dwpr_drive_if.sv
// What this block does
// RULE1: the drive's index sensor toggles once per diskette revolution.
// RULE2: read and write need ready; positioning ignores ready entirely.
// RULE3: write gate rises before the first write data pulse.
// RULE4: write fault shares the separator enable pin; outside logic splits them. This block has separate write_fault_in and separator_enable pins.
// RULE5: inner track flag is high for tracks beyond 43.
// RULE6: single density writes take no precompensation; early and late unused.
// RULE7: double density holds early or late 125 ns around each pulse.
// RULE8: early or late is chosen from the surrounding written bit pattern.
// RULE9: outside logic delays one unit nominal, two late, none early.
// RULE10: digital precomp counter makes 2 MHz and 4 MHz clocks.
// RULE11: idle precomp shift register shifts ones, output stays low.
// RULE12: write pulse loads a zero into one of three stages.
// RULE13: mixed FM and MFM systems bypass the digital precomp.
// RULE14: separator window clock strobes raw pulses, centred ideally.
// RULE15: raw pulse outside its window reports CRC or record-not-found error.
// RULE16: phase-lock separator slows for wide pulses, speeds for close ones.
// RULE17: counter separator free-runs, adjusting only the current window.
// RULE18: separator enable rises once head is loaded and pulses are present. This block has no head-load input: it rises in a read once a raw pulse is seen.
// RULE19: sync gate high over all-zero or all-one fields; side variant replaces it.
// RULE20: small counter separator loads 5, counts down, halves for 50% duty.
// RULE21: table counter separator runs at 16 MHz or 8 MHz.
// RULE22: density high selects single, low double; held during operations.
// RULE23: separator gates the window clock synchronously on separator enable.
// RULE24: early and late together count as nominal at the precomp logic.
// RULE25: precomp logic emits one output pulse per write pulse.
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dwpr_drive_if
   import dwpr_pkg::*;
#(
   parameter int SYNC_RUN     = 8,
   parameter bit SIDE_VARIANT = 1'b0
)(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // drive status pins
   input  wire logic        index_pulse,
   input  wire logic        track_zero_sense,
   input  wire logic        ready_in,
   input  wire logic        write_fault_in,
   input  wire logic        density_select_n,
   // write pins
   output logic             write_gate_out,
   output logic             write_pulse,
   output logic             early_out,
   output logic             late_out,
   output logic             inner_track_flag,
   // read separator pins
   input  wire logic        raw_read_pulse,
   input  wire logic        read_window_clk,
   output logic             separator_enable,
   output logic             sync_field_gate,
   output logic             side_select_out
);
   dwpr_state_e state_reg;
   logic [6:0]  pin_meta_reg, pin_sync_reg;
   logic        dens_n_s, idx_s, trk0_s, rdy_s, wf_s, raw_s, rclk_s;
   logic        wr_pend_reg, rd_pend_reg;
   logic [7:0]  addr_reg, track_reg, wdata_reg, sh_reg, cyc_reg, win_cnt_reg;
   logic        side_reg, dd_reg, prev_reg;
   logic [3:0]  half_reg;
   logic        nrdy_reg, crc_reg, rnf_reg, wfault_reg, synced_reg, saw_reg;
   logic        raw_d_reg, rclk_d_reg;
   logic [1:0]  per_cnt_reg;
   logic [7:0]  run_reg;
   logic        cmd_stb, abort, cmd_start, half_end, want, early_next, late_next;
   logic        raw_rise, rclk_rise, rclk_edge, win_err, sync_hit;
   logic [7:0]  half_len;
   logic [1:0]  op;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // pins cross into hclk; only the second stage is read
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         pin_meta_reg <= 7'h00;
         pin_sync_reg <= 7'h00;
      end
      else
      begin
         pin_meta_reg <= {density_select_n, index_pulse, track_zero_sense, ready_in,
                          write_fault_in, raw_read_pulse, read_window_clk};
         pin_sync_reg <= pin_meta_reg;
      end
   assign {dens_n_s, idx_s, trk0_s, rdy_s, wf_s, raw_s, rclk_s} = pin_sync_reg;

   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      case (a)
         TRACK_OFS:  rd_mux = {24'h00_0000, track_reg};
         WDATA_OFS:  rd_mux = {24'h00_0000, wdata_reg};
         CTRL_OFS:   rd_mux = {31'h0000_0000, side_reg};
         STATUS_OFS: rd_mux = {24'h00_0000, synced_reg, wfault_reg, idx_s, trk0_s,
                               rnf_reg, crc_reg, nrdy_reg, state_reg != ST_IDLE};
         default:    rd_mux = 32'h0000_0000;
      endcase
   endfunction

   // zero-wait slave: address latched, write applied in the data phase
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
         hrdata      <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
         rd_pend_reg <= hsel && htrans[1] && hready && !hwrite;
         if (hsel && htrans[1] && hready)
            addr_reg <= haddr;
         if (hsel && htrans[1] && hready && !hwrite)
            hrdata <= rd_mux(haddr);
      end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         track_reg <= 8'h00;
         wdata_reg <= 8'h00;
         side_reg  <= 1'b0;
      end
      else if (wr_pend_reg)
      begin
         if (addr_reg == TRACK_OFS)
            track_reg <= hwdata[7:0];
         if (addr_reg == WDATA_OFS)
            wdata_reg <= hwdata[7:0];
         if (addr_reg == CTRL_OFS)
            side_reg <= hwdata[0];
      end

   assign op        = hwdata[1:0];
   assign cmd_stb   = wr_pend_reg && addr_reg == CMD_OFS;
   assign abort     = cmd_stb && op == OP_ABORT;
   assign cmd_start = cmd_stb && op != OP_ABORT && state_reg == ST_IDLE;
   assign half_len  = dd_reg ? 8'(DD_HALF_CYC) : 8'(SD_HALF_CYC);
   assign half_end  = cyc_reg == half_len - 8'h01;

   // sequencer; positioning completes at once without looking at ready
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         state_reg <= ST_IDLE;
      else
         case (state_reg)
            ST_IDLE:
               if (cmd_start && rdy_s && op == OP_READ)
                  state_reg <= ST_READ; // RULE2
               else if (cmd_start && rdy_s && op == OP_WRITE)
                  state_reg <= ST_LEAD; // RULE2 RULE3
            ST_LEAD:
               if (abort || wf_s)
                  state_reg <= ST_IDLE;
               else if (cyc_reg == 8'(WG_LEAD_CYC - 1))
                  state_reg <= ST_WRITE;
            ST_WRITE:
               if (abort || wf_s || (half_end && half_reg == LAST_HALF))
                  state_reg <= ST_IDLE;
            ST_READ:
               if (abort)
                  state_reg <= ST_IDLE;
            default:
               state_reg <= ST_IDLE;
         endcase

   // density is latched at start so a mid-operation change has no effect
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         dd_reg <= 1'b0;
      else if (cmd_start)
         dd_reg <= !dens_n_s; // RULE22

   // cell timing and bit pattern for the write stream
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         cyc_reg  <= 8'h00;
         half_reg <= 4'h0;
         sh_reg   <= 8'h00;
         prev_reg <= 1'b0;
      end
      else if (state_reg == ST_IDLE)
      begin
         cyc_reg  <= 8'h00;
         half_reg <= 4'h0;
         if (cmd_start)
            sh_reg <= wdata_reg;
      end
      else if (state_reg == ST_LEAD)
         cyc_reg <= (cyc_reg == 8'(WG_LEAD_CYC - 1)) ? 8'h00 : cyc_reg + 8'h01;
      else if (state_reg == ST_WRITE)
      begin
         cyc_reg <= half_end ? 8'h00 : cyc_reg + 8'h01;
         if (half_end)
            half_reg <= half_reg + 4'h1;
         if (half_end && half_reg[0])
         begin
            prev_reg <= sh_reg[7];
            sh_reg   <= {sh_reg[6:0], 1'b0};
         end
      end

   // mfm clock pulse only between two zeros; fm writes every clock
   assign want = half_reg[0] ? sh_reg[7] : (!dd_reg || (!prev_reg && !sh_reg[7]));
   // a one next to a lone neighbour is pushed away from the crowd
   assign early_next = dd_reg && half_reg[0] && sh_reg[7] && !prev_reg && sh_reg[6]; // RULE8
   assign late_next  = dd_reg && half_reg[0] && sh_reg[7] && prev_reg && !sh_reg[6]; // RULE8

   // flags span the whole half cell; pulse sits mid-cell, well inside them
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         write_gate_out <= 1'b0;
         write_pulse    <= 1'b0;
         early_out      <= 1'b0;
         late_out       <= 1'b0;
      end
      else
      begin
         write_gate_out <= state_reg == ST_LEAD || state_reg == ST_WRITE; // RULE3
         write_pulse    <= state_reg == ST_WRITE && want && cyc_reg >= (half_len >> 1)
                           && cyc_reg < (half_len >> 1) + 8'(PULSE_CYC);
         early_out      <= state_reg == ST_WRITE && early_next; // RULE7
         late_out       <= state_reg == ST_WRITE && late_next; // RULE7
      end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         inner_track_flag <= 1'b0;
      else
         inner_track_flag <= track_reg > INNER_TRACK; // RULE5

   // read window tracking from the sampled window clock
   assign raw_rise  = raw_s && !raw_d_reg;
   assign rclk_rise = rclk_s && !rclk_d_reg;
   assign rclk_edge = rclk_s ^ rclk_d_reg;
   // a pulse too close to a window edge has fallen outside its window
   assign win_err   = state_reg == ST_READ && raw_rise
                      && (rclk_edge || win_cnt_reg < 8'(GUARD_CYC));
   assign sync_hit  = run_reg >= 8'(SYNC_RUN);

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         raw_d_reg   <= 1'b0;
         rclk_d_reg  <= 1'b0;
         win_cnt_reg <= 8'h00;
         per_cnt_reg <= 2'h0;
         run_reg     <= 8'h00;
      end
      else
      begin
         raw_d_reg   <= raw_s;
         rclk_d_reg  <= rclk_s;
         win_cnt_reg <= rclk_edge ? 8'h00 : win_cnt_reg + {7'h00, win_cnt_reg != 8'hff};
         if (rclk_rise)
         begin
            per_cnt_reg <= {1'b0, raw_rise};
            // exactly one pulse per window period means a uniform field
            run_reg     <= (per_cnt_reg == 2'h1) ? run_reg + {7'h00, !sync_hit} : 8'h00;
         end
         else if (raw_rise && per_cnt_reg != 2'h3)
            per_cnt_reg <= per_cnt_reg + 2'h1;
      end

   // sticky status: cleared by a new command, an event in that cycle still sets
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         nrdy_reg   <= 1'b0;
         crc_reg    <= 1'b0;
         rnf_reg    <= 1'b0;
         wfault_reg <= 1'b0;
         synced_reg <= 1'b0;
         saw_reg    <= 1'b0;
      end
      else
      begin
         if (cmd_start)
         begin
            nrdy_reg   <= 1'b0;
            crc_reg    <= 1'b0;
            rnf_reg    <= 1'b0;
            wfault_reg <= 1'b0;
            synced_reg <= 1'b0;
            saw_reg    <= 1'b0;
         end
         if (cmd_start && !rdy_s && (op == OP_READ || op == OP_WRITE))
            nrdy_reg <= 1'b1; // RULE2
         if (win_err && synced_reg)
            crc_reg <= 1'b1; // RULE15
         if (win_err && !synced_reg)
            rnf_reg <= 1'b1; // RULE15
         if ((state_reg == ST_LEAD || state_reg == ST_WRITE) && wf_s)
            wfault_reg <= 1'b1;
         if (state_reg == ST_READ && sync_hit)
            synced_reg <= 1'b1;
         if (state_reg == ST_READ && raw_rise)
            saw_reg <= 1'b1;
      end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         separator_enable <= 1'b0;
         sync_field_gate  <= 1'b0;
         side_select_out  <= 1'b0;
      end
      else
      begin
         separator_enable <= state_reg == ST_READ && saw_reg; // RULE18
         sync_field_gate  <= !SIDE_VARIANT && state_reg == ST_READ && saw_reg
                             && sync_hit; // RULE19
         side_select_out  <= SIDE_VARIANT && side_reg; // RULE19
      end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_wg_rise;
      $rose(write_gate_out);
   endsequence
   sequence s_quiet;
      !write_pulse [*8];
   endsequence
   property p_wg_lead;
      s_wg_rise |-> s_quiet;
   endproperty
   a_wg_lead: assert property (p_wg_lead) else $error("pulse too soon after gate"); // RULE3
   property p_wg_cover;
      write_pulse |-> write_gate_out;
   endproperty
   a_wg_cover: assert property (p_wg_cover) else $error("pulse without gate"); // RULE3
   property p_rdy_block;
      cmd_start && !rdy_s && (op == OP_READ || op == OP_WRITE)
         |=> state_reg == ST_IDLE ##1 nrdy_reg;
   endproperty
   a_rdy_block: assert property (p_rdy_block) else $error("read ran when not ready"); // RULE2
   property p_pos_free;
      cmd_start && op == OP_POSITION |=> ##1 !nrdy_reg;
   endproperty
   a_pos_free: assert property (p_pos_free) else $error("positioning checked ready"); // RULE2
   property p_inner;
      ##1 inner_track_flag == ($past(track_reg) > INNER_TRACK);
   endproperty
   a_inner: assert property (p_inner) else $error("inner track flag wrong"); // RULE5
   property p_flag_pre;
      $rose(write_pulse) && (early_out || late_out)
         |-> $past(early_out, 16) == early_out && $past(late_out, 16) == late_out;
   endproperty
   a_flag_pre: assert property (p_flag_pre) else $error("flag not set early"); // RULE7
   property p_flag_post;
      $fell(write_pulse) && (early_out || late_out) |-> ##15 (early_out || late_out);
   endproperty
   a_flag_post: assert property (p_flag_post) else $error("flag dropped early"); // RULE7
   property p_excl;
      !(early_out && late_out) and (!dd_reg |-> !early_out && !late_out);
   endproperty
   a_excl: assert property (p_excl) else $error("bad precomp flags"); // RULE8
   property p_win;
      win_err |=> ##1 (crc_reg || rnf_reg);
   endproperty
   a_win: assert property (p_win) else $error("window error not reported"); // RULE15
   property p_sep;
      separator_enable |-> $past(state_reg) == ST_READ && $past(saw_reg);
   endproperty
   a_sep: assert property (p_sep) else $error("separator enabled without data"); // RULE18
   property p_sync;
      sync_field_gate |-> separator_enable;
   endproperty
   a_sync: assert property (p_sync) else $error("sync gate without enable"); // RULE19
endmodule
`default_nettype wire

// ### test/dwpr_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module dwpr_drive_model
#(
   parameter int REV_NS   = 20000,
   parameter int PHASE_NS = 8
)(
   // bench controls
   input  wire logic ready_cmd,
   input  wire logic fault_cmd,
   input  wire logic at_zero,
   input  wire logic read_on,
   // write pins from the controller
   input  wire logic write_pulse,
   input  wire logic early_out,
   input  wire logic late_out,
   input  wire logic precomp_en,
   // drive and separator pins
   output logic      index_pulse,
   output logic      track_zero_sense,
   output logic      ready_in,
   output logic      write_fault_in,
   output logic      raw_read_pulse,
   output logic      read_window_clk,
   // precompensated write data toward the drive
   output logic      precomp_out
);
   assign ready_in         = ready_cmd;
   assign write_fault_in   = fault_cmd;
   assign track_zero_sense = at_zero;

   // digital precomp: ones shift through, a zero marks one pulse on its way out
   logic       shift_clk = 1'b0;
   logic       wp_seen = 1'b0;
   logic [3:0] stage_sr = 4'hf;
   logic [1:0] load_at;
   always #125 shift_clk = ~shift_clk;
   // late loads furthest from the output, early nearest; both flags mean nominal
   assign load_at = (late_out && !early_out) ? 2'h0 : (early_out && !late_out) ? 2'h2 : 2'h1;
   // edge detect: a pulse wider than a shift period must load only once
   always @(posedge shift_clk)
   begin
      wp_seen <= write_pulse === 1'b1;
      if (write_pulse === 1'b1 && !wp_seen)
         stage_sr <= {stage_sr[2:0], 1'b1} & ~(4'h1 << load_at);
      else
         stage_sr <= {stage_sr[2:0], 1'b1};
   end
   // without precomp the write pulse bypasses the shifter
   assign precomp_out = precomp_en ? !stage_sr[3] : write_pulse;

   // one index mark per revolution
   initial
   begin
      index_pulse = 1'b0;
      forever
      begin
         #(REV_NS - 400);
         index_pulse = 1'b1;
         #400;
         index_pulse = 1'b0;
      end
   end

   // window clock runs only inside a read frame, then stands still low
   initial
   begin
      read_window_clk = 1'b0;
      raw_read_pulse  = 1'b0;
      forever
      begin
         wait (read_on === 1'b1);
         #3;
         // gating only between whole periods keeps glitches off the window clock
         while (read_on === 1'b1)
         begin
            read_window_clk = 1'b1;
            #PHASE_NS;
            raw_read_pulse = 1'b1;
            #16;
            raw_read_pulse = 1'b0;
            #(40 - PHASE_NS - 16);
            read_window_clk = 1'b0;
            #40;
         end
      end
   end
endmodule
`default_nettype wire

// ### test/dwpr_drive_if_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dwpr_drive_if_tb;
   import dwpr_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   wire logic   hreadyout;
   wire logic   hresp;
   wire logic [31:0] hrdata;
   logic        density_select_n = 1'b0;
   logic        ready_cmd = 1'b1;
   logic        fault_cmd = 1'b0;
   logic        at_zero = 1'b0;
   logic        read_on = 1'b0;
   wire logic   index_pulse, track_zero_sense, ready_in, write_fault_in;
   wire logic   raw_read_pulse, read_window_clk;
   wire logic   write_gate_out, write_pulse, early_out, late_out, inner_track_flag;
   wire logic   separator_enable, sync_field_gate, side_select_out;
   int          n_errors = 0;
   int          n_compared = 0;
   int          n_pulse = 0, n_early = 0, n_late = 0, n_bad = 0, post = 0, fl_cnt = 0;
   logic        wp_d = 1'b0;
   logic        po_d = 1'b0;
   int          n_out = 0;
   wire logic   precomp_out;
   logic [31:0] rd;

   always #4 hclk = ~hclk;

   dwpr_drive_if #(.SYNC_RUN(4), .SIDE_VARIANT(1'b0)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .index_pulse(index_pulse), .track_zero_sense(track_zero_sense), .ready_in(ready_in),
      .write_fault_in(write_fault_in), .density_select_n(density_select_n),
      .write_gate_out(write_gate_out), .write_pulse(write_pulse), .early_out(early_out),
      .late_out(late_out), .inner_track_flag(inner_track_flag),
      .raw_read_pulse(raw_read_pulse), .read_window_clk(read_window_clk),
      .separator_enable(separator_enable), .sync_field_gate(sync_field_gate),
      .side_select_out(side_select_out));

   dwpr_drive_model i_drive (
      .ready_cmd(ready_cmd), .fault_cmd(fault_cmd), .at_zero(at_zero), .read_on(read_on),
      .index_pulse(index_pulse), .track_zero_sense(track_zero_sense), .ready_in(ready_in),
      .write_fault_in(write_fault_in), .raw_read_pulse(raw_read_pulse),
      .read_window_clk(read_window_clk), .write_pulse(write_pulse), .early_out(early_out),
      .late_out(late_out), .precomp_en(!density_select_n), .precomp_out(precomp_out));

   // pulse monitor: gate ahead of every pulse, flag margins around flagged pulses
   always @(posedge hclk)
   begin
      if (write_pulse === 1'b1 && wp_d !== 1'b1)
      begin
         n_pulse++;
         if (early_out === 1'b1) n_early++;
         if (late_out === 1'b1) n_late++;
         if (write_gate_out !== 1'b1) n_bad++;
         if ((early_out | late_out) === 1'b1 && fl_cnt < FLAG_MIN_CYC) n_bad++;
      end
      if (wp_d === 1'b1 && write_pulse !== 1'b1 && (early_out | late_out) === 1'b1)
         post = FLAG_MIN_CYC;
      else if (post > 0)
      begin
         if ((early_out | late_out) !== 1'b1) n_bad++;
         post--;
      end
      fl_cnt = ((early_out | late_out) === 1'b1) ? fl_cnt + 1 : 0;
      wp_d = write_pulse;
      if (precomp_out === 1'b1 && po_d !== 1'b1) n_out++;
      po_d = precomp_out;
   end

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // single word transfer, master holds each phase until hready is sampled high
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 20000; i++)
      begin
         ahb(1'b0, STATUS_OFS, 32'h0);
         if (rd[0] === 1'b0) break;
      end
      check("busy", 32'h0, {31'h0, rd[0]});
   endtask

   task automatic t_reset;
      check("pins_idle", 32'h0, {24'h0, write_gate_out, write_pulse, early_out, late_out,
            inner_track_flag, separator_enable, sync_field_gate, side_select_out});
      check("hreadyout", 32'h1, {31'h0, hreadyout});
      at_zero <= 1'b1;
      repeat (4) @(posedge hclk);
      ahb(1'b0, STATUS_OFS, 32'h0);
      check("track0_bit", 32'h1, {31'h0, rd[4]});
      ahb(1'b1, 8'h14, 32'hffff_ffff);
      ahb(1'b0, 8'h14, 32'h0);
      check("unmapped", 32'h0, rd);
      ahb(1'b1, CTRL_OFS, 32'h0000_0001);
      ahb(1'b0, CTRL_OFS, 32'h0);
      check("ctrl_side", 32'h1, rd);
      check("side_out", 32'h0, {31'h0, side_select_out});
   endtask

   task automatic t_track;
      ahb(1'b1, TRACK_OFS, 32'h0000_002b);
      ahb(1'b0, TRACK_OFS, 32'h0);
      check("track_reg", 32'h0000_002b, rd);
      repeat (3) @(posedge hclk);
      check("inner_43", 32'h0, {31'h0, inner_track_flag});
      ahb(1'b1, TRACK_OFS, 32'h0000_002c);
      repeat (3) @(posedge hclk);
      check("inner_44", 32'h1, {31'h0, inner_track_flag});
   endtask

   task automatic t_ready;
      ready_cmd <= 1'b0;
      repeat (4) @(posedge hclk);
      ahb(1'b1, CMD_OFS, {30'h0, OP_WRITE});
      repeat (8) @(posedge hclk);
      check("gate_not_ready", 32'h0, {31'h0, write_gate_out});
      ahb(1'b0, STATUS_OFS, 32'h0);
      check("not_ready_bit", 32'h1, {31'h0, rd[1]});
      ahb(1'b1, CMD_OFS, {30'h0, OP_POSITION});
      wait_idle();
      check("position_no_ready", 32'h0, {31'h0, rd[1]});
      ready_cmd <= 1'b1;
      repeat (4) @(posedge hclk);
   endtask

   task automatic t_write(input logic sd, input int exp_p, input int exp_e, input int exp_l);
      density_select_n <= sd;
      repeat (4) @(posedge hclk);
      n_pulse = 0;
      n_early = 0;
      n_late = 0;
      n_bad = 0;
      n_out = 0;
      ahb(1'b1, WDATA_OFS, 32'h0000_00d2);
      ahb(1'b1, CMD_OFS, {30'h0, OP_WRITE});
      wait_idle();
      repeat (40) @(posedge hclk);
      check("pulse_count", exp_p, n_pulse);
      check("early_count", exp_e, n_early);
      check("late_count", exp_l, n_late);
      check("gate_and_margin", 32'h0, n_bad);
      check("precomp_out", exp_p, n_out);
      density_select_n <= 1'b0;
   endtask

   task automatic t_fault;
      int i;
      ahb(1'b1, WDATA_OFS, 32'h0000_00ff);
      ahb(1'b1, CMD_OFS, {30'h0, OP_WRITE});
      for (i = 0; i < 400 && write_gate_out !== 1'b1; i++) @(posedge hclk);
      fault_cmd <= 1'b1;
      repeat (300) @(posedge hclk);
      check("gate_after_fault", 32'h0, {31'h0, write_gate_out});
      ahb(1'b0, STATUS_OFS, 32'h0);
      check("fault_status", 32'h40, {24'h0, rd[7:0]} & 32'h41);
      fault_cmd <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask

   task automatic t_read;
      int i;
      read_on <= 1'b1;
      ahb(1'b1, CMD_OFS, {30'h0, OP_READ});
      for (i = 0; i < 200 && separator_enable !== 1'b1; i++) @(posedge hclk);
      check("sep_enable", 32'h1, {31'h0, separator_enable});
      repeat (100) @(posedge hclk);
      ahb(1'b0, STATUS_OFS, 32'h0);
      check("window_error", 32'h1, {31'h0, rd[2] | rd[3]});
      check("synced_bit", 32'h1, {31'h0, rd[7]});
      check("sync_gate", 32'h1, {31'h0, sync_field_gate});
      ahb(1'b1, CMD_OFS, {30'h0, OP_ABORT});
      read_on <= 1'b0;
      repeat (8) @(posedge hclk);
      check("sep_off", 32'h0, {31'h0, separator_enable});
      check("sync_off", 32'h0, {31'h0, sync_field_gate});
   endtask

   initial
   begin
      repeat (80000) @(posedge hclk);
      n_errors++;
      tally_and_finish();
   end

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_track();
      t_write(1'b0, 5, 1, 1);
      t_write(1'b1, 12, 0, 0);
      t_ready();
      t_fault();
      t_read();
      tally_and_finish();
   end
endmodule
`default_nettype wire
